// *** logic/isec_pkg.sv ***
// Constants and types of the isolated switch enable control.
// Assumes a 200 MHz system clock; all timing counts derive from it.
package isec_pkg;

  // ****************************************************************
  // Clock
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // Primary loss timeout before the output is dropped
  localparam int TIMEOUT_NS = 10000;
  localparam logic [11:0] TIMEOUT_CYC = 12'((TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] TIMEOUT_LAST = TIMEOUT_CYC - 12'h001;
  // One-shot pulse width
  localparam int PULSE_NS = 1000;
  localparam logic [7:0] PULSE_CYC = 8'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PULSE_LAST = PULSE_CYC - 8'h01;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic GOOD_RST = 1'b0;
  localparam logic GATE_RST = 1'b0;
  localparam logic KEEP_OFF_RST = 1'b1;

  // ****************************************************************
  // One-shot sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ISEC_IDLE = 2'b00,
    ISEC_PULSE = 2'b01,
    ISEC_WAIT_LOW = 2'b11
  } isec_state_e;

endpackage : isec_pkg

// *** logic/isec_uvlo_if.sv ***
// Comparator levels and power-good state of one supply rail.
// Driven by the control core, resolved by the hysteresis tracker.
`timescale 1ns/1ps
interface isec_uvlo_if;
  logic above_rise;
  logic below_fall;
  logic good;
  modport tracker (input above_rise, input below_fall, output good);
  modport user (output above_rise, output below_fall, input good);
endinterface : isec_uvlo_if

// *** logic/isec_uvlo_track.sv ***
// Hysteresis power-good tracker for one supply rail.
// Assumes comparator levels synchronous to clk_sys_i.
`timescale 1ns/1ps
module isec_uvlo_track (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  isec_uvlo_if.tracker uvlo
);
  import isec_pkg::*;

  logic good_reg;
  logic good_next;

  // Falling threshold wins over rising
  assign good_next = uvlo.below_fall ? 1'b0 : (uvlo.above_rise ? 1'b1 : good_reg);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      good_reg <= GOOD_RST;
    end else begin
      good_reg <= good_next;
    end
  end

  assign uvlo.good = good_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  uv_fall_low_a: assert property (uvlo.below_fall |=> !uvlo.good)
    else $error("rail stays good below falling threshold");
  uv_rise_high_a: assert property (uvlo.above_rise && !uvlo.below_fall |=> uvlo.good)
    else $error("rail not good above rising threshold");
  uv_hyst_hold_a: assert property (!uvlo.above_rise && !uvlo.below_fall |=> $stable(uvlo.good))
    else $error("power-good changed inside hysteresis band");

endmodule : isec_uvlo_track

// *** logic/isec_core.sv ***
// Gate-drive output control of the isolated switch.
// Assumes all inputs synchronous to clk_sys_i; straps stable at reset release.
`timescale 1ns/1ps

// Operation
// - Standard mode: output follows enable
// - One-shot: each enable rise gives one pulse
// - No new pulse until enable returned low
// - One-shot only in three-wire mode
// - High rail down forces output low
// - Primary lost: output low after timeout
// - Primary good with rise/fall hysteresis
// - High rail good with rise/fall hysteresis
// - High rail droop forces output low
// - Wire mode latched until power cycle
// - High or mid rail low forces low
// - Thermal shutdown stops transfer; output low while primary good
module isec_core (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic enable_i,
  input wire logic three_wire_strap_i,
  input wire logic oneshot_strap_i,
  input wire logic primary_supply_above_rise_i,
  input wire logic primary_supply_below_fall_i,
  input wire logic secondary_high_rail_above_rise_i,
  input wire logic secondary_high_rail_below_fall_i,
  input wire logic secondary_mid_rail_above_rise_i,
  input wire logic secondary_mid_rail_below_fall_i,
  input wire logic thermal_shutdown_i,
  output logic gate_drive_out_o,
  output logic keep_off_o,
  output logic power_xfer_en_o,
  output logic three_wire_mode_o,
  output logic oneshot_mode_o,
  output logic primary_good_o,
  output logic high_rail_good_o
);
  import isec_pkg::*;

  // ****************************************************************
  // Rail power-good trackers
  // ****************************************************************
  isec_uvlo_if prim_if ();
  isec_uvlo_if high_if ();
  isec_uvlo_if mid_if ();

  assign prim_if.above_rise = primary_supply_above_rise_i;
  assign prim_if.below_fall = primary_supply_below_fall_i;
  assign high_if.above_rise = secondary_high_rail_above_rise_i;
  assign high_if.below_fall = secondary_high_rail_below_fall_i;
  assign mid_if.above_rise = secondary_mid_rail_above_rise_i;
  assign mid_if.below_fall = secondary_mid_rail_below_fall_i;

  isec_uvlo_track u_prim (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .uvlo(prim_if));
  isec_uvlo_track u_high (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .uvlo(high_if));
  isec_uvlo_track u_mid (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .uvlo(mid_if));

  wire p_good = prim_if.good;
  wire h_good = high_if.good;
  wire m_good = mid_if.good;

  // ****************************************************************
  // Wire mode capture
  // ****************************************************************
  logic mode_cap_reg;
  logic three_wire_reg;
  logic oneshot_reg;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_cap_reg <= 1'b0;
      three_wire_reg <= 1'b0;
      oneshot_reg <= 1'b0;
    end else if (!mode_cap_reg) begin
      mode_cap_reg <= 1'b1;
      three_wire_reg <= three_wire_strap_i;
      oneshot_reg <= oneshot_strap_i & three_wire_strap_i;
    end
  end

  // ****************************************************************
  // Qualifiers
  // ****************************************************************
  wire rails_ok = h_good & m_good;
  wire run_ok = p_good & rails_ok & ~thermal_shutdown_i;

  // ****************************************************************
  // Primary loss timeout
  // ****************************************************************
  logic [11:0] to_cnt_reg;
  logic [11:0] to_cnt_next;
  wire to_expired = (to_cnt_reg == TIMEOUT_LAST);
  wire to_running = ~p_good & h_good;

  assign to_cnt_next = !to_running ? 12'h000 :
                       (to_expired ? to_cnt_reg : to_cnt_reg + 12'h001);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      to_cnt_reg <= 12'h000;
    end else begin
      to_cnt_reg <= to_cnt_next;
    end
  end

  // ****************************************************************
  // One-shot sequencer
  // ****************************************************************
  isec_state_e state_reg;
  isec_state_e state_next;
  logic [7:0] pulse_cnt_reg;
  logic [7:0] pulse_cnt_next;

  // Starts in wait-low so enable must be seen low first
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ISEC_IDLE: begin
        if (oneshot_reg && run_ok && enable_i) begin
          state_next = ISEC_PULSE;
        end
      end
      ISEC_PULSE: begin
        if (pulse_cnt_reg == PULSE_LAST) begin
          state_next = ISEC_WAIT_LOW;
        end
      end
      ISEC_WAIT_LOW: begin
        if (!enable_i) begin
          state_next = ISEC_IDLE;
        end
      end
      default: begin
        state_next = ISEC_WAIT_LOW;
      end
    endcase
  end

  assign pulse_cnt_next = (state_reg == ISEC_PULSE) ? pulse_cnt_reg + 8'h01 : 8'h00;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ISEC_WAIT_LOW;
      pulse_cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      pulse_cnt_reg <= pulse_cnt_next;
    end
  end

  // ****************************************************************
  // Gate drive decision
  // ****************************************************************
  logic gate_next;
  logic keep_off_next;
  wire mode_level = oneshot_reg ? (state_next == ISEC_PULSE) : enable_i;
  // Without primary, hold the last level until the timeout ends
  wire prim_lost_level = to_expired ? 1'b0 : gate_drive_out_o;

  assign gate_next = !rails_ok ? 1'b0 :
                     (!p_good ? prim_lost_level :
                     (thermal_shutdown_i ? 1'b0 : mode_level));
  assign keep_off_next = ~rails_ok | (~p_good & to_expired);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gate_drive_out_o <= GATE_RST;
      keep_off_o <= KEEP_OFF_RST;
      power_xfer_en_o <= 1'b0;
      three_wire_mode_o <= 1'b0;
      oneshot_mode_o <= 1'b0;
      primary_good_o <= GOOD_RST;
      high_rail_good_o <= GOOD_RST;
    end else begin
      gate_drive_out_o <= gate_next;
      keep_off_o <= keep_off_next;
      power_xfer_en_o <= p_good & ~thermal_shutdown_i;
      three_wire_mode_o <= three_wire_reg;
      oneshot_mode_o <= oneshot_reg;
      primary_good_o <= p_good;
      high_rail_good_o <= h_good;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence pulse_end_s;
    state_reg == ISEC_PULSE && pulse_cnt_reg == PULSE_LAST;
  endsequence

  sequence wait_low_s;
    state_reg == ISEC_WAIT_LOW;
  endsequence

  std_follow_en_a: assert property (!oneshot_reg && run_ok |=> gate_drive_out_o == $past(enable_i))
    else $error("standard mode output does not follow enable");
  pulse_end_a: assert property (pulse_end_s ##0 run_ok |=> wait_low_s ##0 !gate_drive_out_o)
    else $error("one-shot pulse did not end at its width");
  pulse_start_a: assert property ($rose(state_reg == ISEC_PULSE) |-> pulse_cnt_reg == 8'h00)
    else $error("pulse started with stale width count");
  no_rearm_high_a: assert property (wait_low_s ##0 enable_i |=> wait_low_s ##0 (!oneshot_reg || !gate_drive_out_o))
    else $error("new pulse without enable returning low");
  oneshot_3w_a: assert property (oneshot_reg |-> three_wire_reg)
    else $error("one-shot active outside three-wire mode");
  high_down_low_a: assert property (!h_good |=> !gate_drive_out_o && keep_off_o)
    else $error("output not held off with high rail down");
  prim_timeout_a: assert property (to_expired && !p_good && h_good |=> !gate_drive_out_o)
    else $error("output not dropped after primary timeout");
  timeout_count_a: assert property (to_running && !to_expired |=> to_cnt_reg == $past(to_cnt_reg) + 12'h001)
    else $error("primary loss timeout not counting");
  droop_low_a: assert property ($fell(h_good) |-> ##[0:1] !gate_drive_out_o)
    else $error("rail droop did not force output low");
  mode_latched_a: assert property (mode_cap_reg |=> $stable(three_wire_reg) && $stable(oneshot_reg))
    else $error("wire mode changed after capture");
  mid_down_low_a: assert property (!m_good |=> !gate_drive_out_o)
    else $error("output high with mid rail down");
  thermal_off_a: assert property (thermal_shutdown_i && p_good |=> !gate_drive_out_o && !power_xfer_en_o)
    else $error("thermal shutdown did not stop output");

endmodule : isec_core

// *** sim/isec_gate_model.sv ***
// Behavioural model of the external power switch on the gate-drive output.
// Assumes the drive and keep-off levels come from registered outputs.
`timescale 1ns/1ps
module isec_gate_model (
  input wire logic gate_i,
  input wire logic keep_off_i,
  output logic load_on_o
);
  // ****************************************************************
  // Switch conducts only when driven and not clamped
  // ****************************************************************
  assign load_on_o = gate_i & ~keep_off_i;
endmodule : isec_gate_model

// *** sim/tb_isolated_switch_enable_control.sv ***
// Self-checking bench of the gate-drive output control.
// Assumes the package pulse and timeout counts; 200 MHz clock.
`timescale 1ns/1ps
module tb_isolated_switch_enable_control;
  import isec_pkg::*;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, enable_i = 1'b0, tw = 1'b0, os = 1'b0;
  logic p_rise = 1'b1, p_fall = 1'b0, h_rise = 1'b1, h_fall = 1'b0;
  logic m_rise = 1'b1, m_fall = 1'b0, thermal = 1'b0;
  logic gate, keep_off, xfer, tw_m, os_m, p_good, h_good, load_on, last_en, prev_en;
  int fails = 0, cmp_count = 0, seed = 58436, n;

  always #2.5 clk_sys_i = ~clk_sys_i;

  isec_core i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .enable_i(enable_i),
    .three_wire_strap_i(tw), .oneshot_strap_i(os), .primary_supply_above_rise_i(p_rise),
    .primary_supply_below_fall_i(p_fall), .secondary_high_rail_above_rise_i(h_rise),
    .secondary_high_rail_below_fall_i(h_fall), .secondary_mid_rail_above_rise_i(m_rise),
    .secondary_mid_rail_below_fall_i(m_fall), .thermal_shutdown_i(thermal),
    .gate_drive_out_o(gate), .keep_off_o(keep_off), .power_xfer_en_o(xfer),
    .three_wire_mode_o(tw_m), .oneshot_mode_o(os_m), .primary_good_o(p_good),
    .high_rail_good_o(h_good));

  isec_gate_model i_gate (.gate_i(gate), .keep_off_i(keep_off), .load_on_o(load_on));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask : cyc

  // Gate level expected in standard mode
  function automatic logic exp_gate(input logic en, input logic rails, input logic hot);
    return en & rails & ~hot;
  endfunction : exp_gate

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task report_and_stop;
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Power cycle with new straps
  task do_reset(input logic t, input logic o);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    tw <= t;
    os <= o;
    enable_i <= 1'b0;
    cyc(12);
    arst_n_i <= 1'b1;
    cyc(4);
  endtask : do_reset

  // Number of cycles the output stands high
  task automatic hi_count(input int span, output int k);
    k = 0;
    repeat (span) begin
      @(posedge clk_sys_i);
      if (gate === 1'b1) k++;
    end
  endtask : hi_count

  task raise_en;
    @(posedge clk_sys_i);
    enable_i <= 1'b1;
  endtask : raise_en

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    do_reset(1'b0, 1'b1);
    chk(os_m, 1'b0);
    chk(tw_m, 1'b0);
    last_en = 1'b0;
    prev_en = 1'b0;
    repeat (300) begin
      @(posedge clk_sys_i);
      chk(gate, exp_gate(prev_en, 1'b1, thermal));
      chk(load_on, exp_gate(prev_en, 1'b1, thermal));
      chk(keep_off, 1'b0);
      prev_en = last_en;
      last_en = 1'($random(seed));
      enable_i <= last_en;
    end
    raise_en();
    cyc(3);
    @(posedge clk_sys_i);
    h_fall <= 1'b1;
    h_rise <= 1'b0;
    cyc(4);
    chk(gate, 1'b0);
    chk(keep_off, 1'b1);
    h_fall <= 1'b0;
    cyc(4);
    chk(h_good, 1'b0);
    chk(gate, 1'b0);
    h_rise <= 1'b1;
    cyc(4);
    chk(gate, 1'b1);
    h_rise <= 1'b0;
    cyc(4);
    chk(h_good, 1'b1);
    m_fall <= 1'b1;
    m_rise <= 1'b0;
    cyc(4);
    chk(gate, 1'b0);
    m_fall <= 1'b0;
    m_rise <= 1'b1;
    h_rise <= 1'b1;
    cyc(4);
    chk(gate, 1'b1);
    thermal <= 1'b1;
    cyc(4);
    chk(gate, 1'b0);
    chk(xfer, 1'b0);
    thermal <= 1'b0;
    cyc(4);
    chk(gate, 1'b1);
    chk(xfer, 1'b1);
    p_rise <= 1'b0;
    cyc(4);
    chk(p_good, 1'b1);
    p_fall <= 1'b1;
    cyc(int'(TIMEOUT_CYC) - 10);
    chk(gate, 1'b1);
    chk(p_good, 1'b0);
    cyc(20);
    chk(gate, 1'b0);
    chk(keep_off, 1'b1);
    p_fall <= 1'b0;
    cyc(4);
    chk(p_good, 1'b0);
    p_rise <= 1'b1;
    do_reset(1'b1, 1'b1);
    chk(os_m, 1'b1);
    chk(tw_m, 1'b1);
    tw <= 1'b0;
    os <= 1'b0;
    raise_en();
    hi_count(400, n);
    chk(16'(n), 16'(PULSE_CYC));
    chk(gate, 1'b0);
    hi_count(100, n);
    chk(16'(n), 16'h0000);
    @(posedge clk_sys_i);
    enable_i <= 1'b0;
    raise_en();
    hi_count(400, n);
    chk(16'(n), 16'(PULSE_CYC));
    chk(tw_m, 1'b1);
    chk(os_m, 1'b1);
    report_and_stop();
  end

  // Hang guard, far beyond the expected run
  initial begin
    cyc(20000);
    fails++;
    $display("[ERR] %0t run did not finish", $time);
    report_and_stop();
  end
endmodule : tb_isolated_switch_enable_control
